// File: rtl/fp_pkg.sv
// Purpose: shared constants, types and factory tables of the front panel
// Assumes: hclk at 200 MHz, registers reached over AHB-Lite
// Notes: digits are BCD nibbles, leftmost digit in the top nibble
package fp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;  // system clock rate
  localparam int unsigned HOLD_MS = 2000;  // long press, least time
  localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned DEBOUNCE_MS = 10;  // key settle time
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam logic [2:0] BOOT_CYC = 3'h4;  // wait for key synchronisers

  // ----------------------------------------
  // register map, byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;  // protect lock
  localparam logic [7:0] OFF_STATUS = 8'h04;  // panel state
  localparam logic [7:0] OFF_SEL = 8'h08;  // storage read index
  localparam logic [7:0] OFF_MODE_DATA = 8'h0c;  // stored mode value
  localparam logic [7:0] OFF_PRESET_DATA = 8'h10;  // stored threshold
  localparam logic [7:0] OFF_INPUT_CFG = 8'h14;  // range and type
  localparam logic [7:0] OFF_DISPLAY = 8'h18;  // digits shown now
  localparam logic CTRL_RST = 1'b0;  // protect released after reset
  localparam logic [3:0] SEL_RST = 4'h0;

  // ----------------------------------------
  // display and edit constants
  // ----------------------------------------
  localparam logic [2:0] POS_MODE_FIRST = 3'h1;  // first data digit
  localparam logic [2:0] POS_PRE_FIRST = 3'h0;  // thresholds use all five
  localparam logic [2:0] POS_LAST = 3'h4;  // rightmost digit
  localparam logic [2:0] FLASH_NONE = 3'h7;  // nothing flashes
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [19:0] PRESET_DEFAULT = 20'h99999;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_MEAS = 2'b01,
    ST_MODE = 2'b10,
    ST_PRESET = 2'b11
  } state_e;

  typedef enum logic [2:0] {
    EV_NONE = 3'b000,
    EV_RST = 3'b001,
    EV_COMMIT = 3'b010,
    EV_MODE = 3'b011,
    EV_SHIFT = 3'b100,
    EV_UP = 3'b101,
    EV_DOWN = 3'b110
  } ev_e;

  typedef enum logic [1:0] {
    range_50hz = 2'b00,
    range_1khz = 2'b01,
    response_range_10khz = 2'b10
  } range_e;

  typedef struct packed {
    logic mode_key;
    logic up_key;
    logic down_key;
    logic shift_key;
    logic commit_key;
    logic reset_key;
    logic init_key;
  } key_s;

  typedef struct packed {
    logic preset_channel_one;
    logic preset_channel_two;
    logic preset_channel_three;
    logic preset_channel_four;
  } lamp_s;

  typedef struct packed {
    logic [19:0] digits;
    logic [2:0] flash_pos;
    lamp_s lamp;
  } disp_s;

  // factory value of each mode, digits b to e; blank digits stored as 0
  function automatic logic [15:0] mode_default(input logic [3:0] m);
    logic [15:0] r;
    r = 16'h0000;
    unique case (m)
      4'h0: r = 16'h0021;
      4'h1, 4'h3, 4'h5, 4'hd: r = 16'h1000;
      4'h2, 4'h4: r = 16'h3002;
      4'h6: r = 16'h0020;
      4'hc: r = 16'h0100;
      4'hf: r = 16'h0001;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

endpackage

// File: rtl/key_debounce.sv
// Purpose: synchronise, debounce and edge-detect a group of pins
// Assumes: raw pins are asynchronous to clk, active high
// Notes: press is a one-cycle pulse on each settled rising level
module key_debounce #(
  parameter int W = 7,
  parameter int unsigned CYCLES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] sync,
  output logic [W-1:0] level,
  output logic [W-1:0] press
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  // ----------------------------------------
  // one filter per pin
  // ----------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_pin
    logic s1_q;  // first stage, read by s2 only
    logic s2_q;  // second stage
    logic [CW-1:0] cnt_q;  // time the new level has stood

    // two-flop synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= raw[i];
        s2_q <= s1_q;
      end
    end

    // settle counter, level and press pulse
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= '0;
        level[i] <= 1'b0;
        press[i] <= 1'b0;
      end else begin
        press[i] <= 1'b0;
        if (s2_q == level[i]) begin
          cnt_q <= '0;  // bounce restarts the wait
        end else if (cnt_q == LAST) begin
          cnt_q <= '0;
          level[i] <= s2_q;
          press[i] <= s2_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end

    assign sync[i] = s2_q;
  end

endmodule

// File: rtl/front_panel_mode_setting.sv
// Purpose: front panel settings machine of a speed meter
// Assumes: single clock hclk, asynchronous active-low hresetn as power-on
// Notes: keys and switches are pins; meas_digits comes from on-clock logic

// Function
// RL1 - mode plus shift held 2 s enters setting
// RL2 - entry shows mode 0 and its value
// RL3 - up raises flashing digit, 9 wraps 0
// RL4 - down lowers flashing digit, 0 wraps 9
// RL5 - shift moves flashing digit one right
// RL6 - mode key steps mode number 0..F
// RL7 - commit stores edits, returns to measurement
// RL8 - reset key drops edits, returns unchanged
// RL9 - init key at power loads factory values
// RL10 - init also releases mode protect
// RL11 - thresholds default to all nines
// RL12 - factory values kept per mode number
// RL13 - two switches choose 50Hz, 1kHz, 10kHz range
// RL14 - type switch: open collector or voltage pulse
// RL15 - unspecified input: open collector, fastest range
// RL16 - mode key alone 2 s enters thresholds
// RL17 - protect lock refuses mode setting changes
// RL18 - keys debounced, one action per press; position wraps
// RL19 - entry copies storage to buffer, first digit flashes
module front_panel_mode_setting #(
  parameter int unsigned HOLD_CYCLES = fp_pkg::HOLD_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = fp_pkg::DEBOUNCE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire fp_pkg::key_s key_pins,
  input wire logic [3:0] range_sw,
  input wire logic [1:0] type_sw,
  input wire logic [19:0] meas_digits,
  output fp_pkg::disp_s disp,
  output fp_pkg::range_e range_a,
  output fp_pkg::range_e range_b,
  output logic type_a,
  output logic type_b
);
  import fp_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  key_s key_sync;  // synchronised levels
  key_s key_lvl;  // debounced levels
  key_s key_prs;  // one-cycle press pulses
  logic [5:0] sw_lvl;  // debounced switches
  state_e state_q;
  ev_e ev;  // key event of this cycle
  logic [2:0] boot_cnt_q;
  logic boot_done;
  logic [31:0] hold_cnt_q;
  logic hold_shift_q;  // shift level seen last cycle
  logic hold_hit;  // long press complete
  logic protect_q;  // mode protect lock
  logic init_seen_q;  // factory load happened
  logic [3:0] sel_q;  // storage read index
  logic [3:0] mode_no_q;
  logic [2:0] pos_q;  // flashing digit, 0 is leftmost
  logic [1:0] chan_q;  // threshold channel
  logic [15:0] store_mode_q [16];
  logic [19:0] store_pre_q [4];
  logic [15:0] edit_mode_q [16];
  logic [19:0] edit_pre_q [4];
  logic [19:0] cur_word;  // word under edit
  logic [3:0] cur_dig;
  logic [3:0] up_dig;
  logic [3:0] dn_dig;
  logic edit_ok;  // digit changes allowed
  logic enter_mode;
  logic enter_pre;
  logic wr_pend_q;
  logic [7:0] wr_off_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] dig_get(input logic [19:0] w, input logic [2:0] p);
    int sh;
    sh = 16 - 4 * int'(p);
    return w[sh+:4];
  endfunction

  function automatic logic [19:0] dig_put(input logic [19:0] w, input logic [2:0] p,
                                          input logic [3:0] v);
    logic [19:0] r;
    int sh;
    r = w;
    sh = 16 - 4 * int'(p);
    r[sh+:4] = v;
    return r;
  endfunction

  // two switches to a range, opposite patterns give the slow ranges
  function automatic range_e range_dec(input logic low_on, input logic mid_on);
    if (low_on && !mid_on) return range_50hz;
    if (mid_on && !low_on) return range_1khz;
    return response_range_10khz;
  endfunction

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  // keys: sync, settle, one pulse per press [RL18]
  key_debounce #(.W(7), .CYCLES(DEBOUNCE_CYCLES)) u_keys (
    .clk(hclk),
    .rst_n(hresetn),
    .raw(key_pins),
    .sync(key_sync),
    .level(key_lvl),
    .press(key_prs)
  );

  // switches share the same filter
  key_debounce #(.W(6), .CYCLES(DEBOUNCE_CYCLES)) u_sw (
    .clk(hclk),
    .rst_n(hresetn),
    .raw({type_sw, range_sw}),
    .sync(),
    .level(sw_lvl),
    .press()
  );

  // one event per cycle, reset key first
  always_comb begin
    ev = EV_NONE;
    if (key_prs.reset_key) ev = EV_RST;
    else if (key_prs.commit_key) ev = EV_COMMIT;
    else if (key_prs.mode_key) ev = EV_MODE;
    else if (key_prs.shift_key) ev = EV_SHIFT;
    else if (key_prs.up_key) ev = EV_UP;
    else if (key_prs.down_key) ev = EV_DOWN;
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  assign boot_done = (state_q == ST_BOOT) && (boot_cnt_q == BOOT_CYC - 3'h1);
  assign hold_hit = (state_q == ST_MEAS) && key_lvl.mode_key &&
                    (key_lvl.shift_key == hold_shift_q) &&
                    (hold_cnt_q == HOLD_CYCLES - 1);
  assign enter_mode = hold_hit && key_lvl.shift_key;  // [RL1]
  assign enter_pre = hold_hit && !key_lvl.shift_key;  // [RL16]

  // boot wait so the init key has passed the synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) boot_cnt_q <= 3'h0;
    else if (state_q == ST_BOOT) boot_cnt_q <= boot_cnt_q + 3'h1;
  end

  // long-press timer, restarts when the shift level changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_q <= 32'h0;
      hold_shift_q <= 1'b0;
    end else begin
      hold_shift_q <= key_lvl.shift_key;
      if (state_q != ST_MEAS || !key_lvl.mode_key || key_lvl.shift_key != hold_shift_q) begin
        hold_cnt_q <= 32'h0;
      end else if (hold_cnt_q != HOLD_CYCLES - 1) begin
        hold_cnt_q <= hold_cnt_q + 32'h1;  // [RL1] [RL16]
      end
    end
  end

  // panel state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_BOOT;
    end else begin
      unique case (state_q)
        ST_BOOT: if (boot_done) state_q <= ST_MEAS;
        ST_MEAS: begin
          if (enter_mode) state_q <= ST_MODE;  // [RL1]
          else if (enter_pre) state_q <= ST_PRESET;  // [RL16]
        end
        ST_MODE, ST_PRESET: begin
          if (ev == EV_COMMIT || ev == EV_RST) state_q <= ST_MEAS;  // [RL7] [RL8]
        end
      endcase
    end
  end

  // ----------------------------------------
  // edit buffer
  // ----------------------------------------
  assign cur_word = (state_q == ST_MODE) ? {mode_no_q, edit_mode_q[mode_no_q]} :
                    edit_pre_q[chan_q];
  assign cur_dig = dig_get(cur_word, pos_q);
  assign up_dig = (cur_dig >= DIGIT_MAX) ? 4'h0 : cur_dig + 4'h1;  // [RL3]
  assign dn_dig = (cur_dig == 4'h0 || cur_dig > DIGIT_MAX) ? DIGIT_MAX :
                  cur_dig - 4'h1;  // [RL4]
  assign edit_ok = (state_q == ST_PRESET) || (state_q == ST_MODE && !protect_q);  // [RL17]

  // buffer, mode number, channel and flashing position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_no_q <= 4'h0;
      pos_q <= POS_MODE_FIRST;
      chan_q <= 2'h0;
      for (int i = 0; i < 16; i++) edit_mode_q[i] <= 16'h0;
      for (int i = 0; i < 4; i++) edit_pre_q[i] <= 20'h0;
    end else if (enter_mode) begin
      edit_mode_q <= store_mode_q;  // [RL19]
      mode_no_q <= 4'h0;  // [RL2]
      pos_q <= POS_MODE_FIRST;  // [RL19]
    end else if (enter_pre) begin
      edit_pre_q <= store_pre_q;
      chan_q <= 2'h0;
      pos_q <= POS_PRE_FIRST;
    end else if (state_q == ST_MODE || state_q == ST_PRESET) begin
      unique case (ev)
        EV_MODE: begin
          if (state_q == ST_MODE) begin
            mode_no_q <= mode_no_q + 4'h1;  // [RL6]
            pos_q <= POS_MODE_FIRST;
          end else begin
            chan_q <= chan_q + 2'h1;
            pos_q <= POS_PRE_FIRST;
          end
        end
        EV_SHIFT: begin
          if (pos_q != POS_LAST) pos_q <= pos_q + 3'h1;  // [RL5]
          else if (state_q == ST_MODE) pos_q <= POS_MODE_FIRST;  // [RL18]
          else pos_q <= POS_PRE_FIRST;  // [RL18]
        end
        EV_UP, EV_DOWN: begin
          if (edit_ok && state_q == ST_MODE) begin
            edit_mode_q[mode_no_q] <=
                16'(dig_put(cur_word, pos_q, (ev == EV_UP) ? up_dig : dn_dig));
          end else if (edit_ok) begin
            edit_pre_q[chan_q] <= dig_put(cur_word, pos_q, (ev == EV_UP) ? up_dig : dn_dig);
          end
        end
        EV_NONE, EV_RST, EV_COMMIT: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // stored settings: factory load at boot, commit from the buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) store_mode_q[i] <= 16'h0;
      for (int i = 0; i < 4; i++) store_pre_q[i] <= 20'h0;
    end else if (boot_done && key_sync.init_key) begin
      for (int i = 0; i < 16; i++) store_mode_q[i] <= mode_default(4'(i));  // [RL9] [RL12]
      for (int i = 0; i < 4; i++) store_pre_q[i] <= PRESET_DEFAULT;  // [RL9] [RL11]
    end else if (ev == EV_COMMIT) begin
      if (state_q == ST_MODE && !protect_q) store_mode_q <= edit_mode_q;  // [RL7] [RL17]
      else if (state_q == ST_PRESET) store_pre_q <= edit_pre_q;  // [RL7]
    end
  end

  // ----------------------------------------
  // input configuration
  // ----------------------------------------
  // holds the fastest open-collector setting until switches are read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_a <= response_range_10khz;  // [RL15]
      range_b <= response_range_10khz;  // [RL15]
      type_a <= 1'b1;  // [RL15]
      type_b <= 1'b1;  // [RL15]
    end else if (state_q != ST_BOOT) begin
      range_b <= range_dec(sw_lvl[0], sw_lvl[1]);  // [RL13]
      range_a <= range_dec(sw_lvl[3], sw_lvl[2]);  // [RL13]
      type_b <= sw_lvl[4];  // [RL14]
      type_a <= sw_lvl[5];  // [RL14]
    end
  end

  // ----------------------------------------
  // display
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp <= '{digits: 20'h0, flash_pos: FLASH_NONE, lamp: '0};
    end else begin
      unique case (state_q)
        ST_BOOT: disp <= '{digits: 20'h0, flash_pos: FLASH_NONE, lamp: '0};
        ST_MEAS: disp <= '{digits: meas_digits, flash_pos: FLASH_NONE, lamp: '0};
        ST_MODE: disp <= '{digits: cur_word, flash_pos: pos_q, lamp: '0};  // [RL2]
        ST_PRESET: disp <= '{digits: cur_word, flash_pos: pos_q,
                             lamp: lamp_s'(4'h8 >> chan_q)};
      endcase
    end
  end

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  // control: protect lock and read index, init clears protect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      protect_q <= CTRL_RST;
      sel_q <= SEL_RST;
      init_seen_q <= 1'b0;
    end else if (boot_done && key_sync.init_key) begin
      protect_q <= 1'b0;  // [RL10]
      init_seen_q <= 1'b1;
    end else if (wr_pend_q) begin
      if (wr_off_q == OFF_CTRL) protect_q <= hwdata[0];
      if (wr_off_q == OFF_SEL) sel_q <= hwdata[3:0];
    end
  end

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= 1'b0;
      if (hsel && htrans[1] && hready && haddr[31:8] == 24'h0) begin
        wr_pend_q <= hwrite;
        wr_off_q <= haddr[7:0];
        hrdata <= 32'h0;
        if (!hwrite) begin
          unique case (haddr[7:0])
            OFF_CTRL: hrdata <= {31'h0, protect_q};
            OFF_STATUS: hrdata <= {15'h0, init_seen_q, 2'h0, chan_q, 1'b0, pos_q,
                                   mode_no_q, 2'h0, state_q};
            OFF_SEL: hrdata <= {28'h0, sel_q};
            OFF_MODE_DATA: hrdata <= {16'h0, store_mode_q[sel_q]};
            OFF_PRESET_DATA: hrdata <= {12'h0, store_pre_q[sel_q[1:0]]};
            OFF_INPUT_CFG: hrdata <= {26'h0, type_b, type_a, range_b, range_a};
            OFF_DISPLAY: hrdata <= {9'h0, disp.flash_pos, disp.digits};
            default: hrdata <= 32'h0;
          endcase
        end
      end else if (hsel && htrans[1] && hready) begin
        hrdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_long_press_entry: assert property (@(posedge hclk) disable iff (!hresetn) // [RL1]
    (state_q == ST_MEAS ##1 state_q == ST_MODE) |-> $past(hold_cnt_q) == HOLD_CYCLES - 1)
    else $error("mode setting entered without a full long press");
  a_entry_shows_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
    enter_mode |=> mode_no_q == 4'h0 && pos_q == POS_MODE_FIRST ##1
                   disp.digits == {4'h0, store_mode_q[0]} && disp.flash_pos == POS_MODE_FIRST)
    else $error("entry does not show mode zero with first digit flashing");
  a_up_wraps: assert property (@(posedge hclk) disable iff (!hresetn) // [RL3]
    (ev == EV_UP && edit_ok && cur_dig <= DIGIT_MAX) |=>
      cur_dig == (($past(cur_dig) == DIGIT_MAX) ? 4'h0 : $past(cur_dig) + 4'h1))
    else $error("up key result wrong");
  a_down_wraps: assert property (@(posedge hclk) disable iff (!hresetn) // [RL4]
    (ev == EV_DOWN && edit_ok && cur_dig <= DIGIT_MAX) |=>
      cur_dig == (($past(cur_dig) == 4'h0) ? DIGIT_MAX : $past(cur_dig) - 4'h1))
    else $error("down key result wrong");
  a_shift_moves: assert property (@(posedge hclk) disable iff (!hresetn) // [RL5]
    (state_q == ST_MODE && ev == EV_SHIFT) |=>
      pos_q == (($past(pos_q) == POS_LAST) ? POS_MODE_FIRST : $past(pos_q) + 3'h1))
    else $error("shift key moved the flashing digit wrongly");
  a_mode_steps: assert property (@(posedge hclk) disable iff (!hresetn) // [RL6]
    (state_q == ST_MODE && ev == EV_MODE) |=> mode_no_q == $past(mode_no_q) + 4'h1)
    else $error("mode number did not step");
  a_commit_stores: assert property (@(posedge hclk) disable iff (!hresetn) // [RL7]
    (state_q == ST_MODE && ev == EV_COMMIT && !protect_q) |=>
      store_mode_q[0] == $past(edit_mode_q[0]) && state_q == ST_MEAS)
    else $error("commit did not store and return");
  a_reset_discards: assert property (@(posedge hclk) disable iff (!hresetn) // [RL8]
    (state_q == ST_MODE && ev == EV_RST) |=>
      $stable(store_mode_q[1]) && state_q == ST_MEAS)
    else $error("reset key changed storage or stayed in setting");
  a_init_defaults: assert property (@(posedge hclk) disable iff (!hresetn) // [RL9]
    (boot_done && key_sync.init_key) |=> store_mode_q[0] == 16'h0021 &&
      store_mode_q[5] == 16'h1000 && store_pre_q[3] == 20'h99999 && !protect_q)
    else $error("factory load incomplete");
  a_protect_refuses: assert property (@(posedge hclk) disable iff (!hresetn) // [RL17]
    (state_q == ST_MODE && protect_q && (ev == EV_UP || ev == EV_DOWN)) |=>
      $stable(edit_mode_q[mode_no_q]))
    else $error("locked mode value changed");

endmodule

// File: testbench/panel_operator.sv
// Purpose: operator model driving the panel keys and switches
// Assumes: every change lands just after a rising edge of hclk
// Notes: the init key is held from power on until the bench lets go
module panel_operator #(
  parameter int unsigned DEB = 4,
  parameter int unsigned HOLD = 40
) (
  input wire logic hclk,
  output fp_pkg::key_s key_pins,
  output logic [3:0] range_sw,
  output logic [1:0] type_sw
);
  timeunit 1ns;
  timeprecision 1ps;
  import fp_pkg::*;
  // ----------------------------------------
  // operator actions
  // ----------------------------------------
  // power on: init key down, range switches off, type switches on, both inputs open collector
  initial begin
    key_pins = key_s'(7'h01);
    range_sw = 4'h0;
    type_sw = 2'h3;
  end
  // hold keys for a number of cycles, release, let the release settle
  task automatic act(input key_s k, input int unsigned cyc);
    @(posedge hclk);
    key_pins <= k;
    repeat (cyc) @(posedge hclk);
    key_pins <= '0;
    repeat (DEB + 8) @(posedge hclk);
  endtask
  task automatic press(input key_s k);
    act(k, DEB + 8);  // short, steady past the settle time
  endtask
  task automatic hold(input key_s k);
    act(k, DEB + HOLD + 10);  // long press
  endtask
  // set the range and type switches, then wait for them to settle
  task automatic set_sw(input logic [3:0] r, input logic [1:0] t);
    @(posedge hclk);
    range_sw <= r;
    type_sw <= t;
    repeat (DEB + 8) @(posedge hclk);
  endtask
endmodule

// File: testbench/front_panel_mode_setting_tb_top.sv
// Purpose: self-checking bench of the front panel settings machine
// Assumes: short hold and settle counts, zero wait state bus
// Notes: expected values come from the factory tables and key rules
module front_panel_mode_setting_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fp_pkg::*;
  localparam int unsigned DEB = 4;  // short settle count
  localparam int unsigned HOLD = 40;  // short long-press count
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  key_s key_pins;
  logic [3:0] range_sw;
  logic [1:0] type_sw;
  disp_s disp;
  range_e range_a;
  range_e range_b;
  logic type_a;
  logic type_b;
  int errors = 0;
  int checks = 0;
  always #2.5 hclk = ~hclk;  // 200 MHz
  panel_operator #(.DEB(DEB), .HOLD(HOLD)) i_panel_operator (.hclk(hclk),
    .key_pins(key_pins), .range_sw(range_sw), .type_sw(type_sw));
  front_panel_mode_setting #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB))
    i_front_panel_mode_setting (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .key_pins(key_pins), .range_sw(range_sw), .type_sw(type_sw), .meas_digits(20'h12345),
    .disp(disp), .range_a(range_a), .range_b(range_b), .type_a(type_a), .type_b(type_b));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(n, e, v & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic st(input logic [1:0] s, input logic [3:0] m, input logic [2:0] p);
    rchk("status", OFF_STATUS, {21'h0, p, m, 2'h0, s}, 32'h7f3);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init;
    i_panel_operator.act(key_s'(7'h00), 1);
    chk("range_a", response_range_10khz, range_a);
    chk("type_a", 1'b1, type_a);
    wr(OFF_SEL, 32'h0);
    rchk("mode0", OFF_MODE_DATA, 32'h0021);
    wr(OFF_SEL, 32'h1);
    rchk("mode1", OFF_MODE_DATA, 32'h1000);
    wr(OFF_SEL, 32'h3);
    rchk("preset4", OFF_PRESET_DATA, 32'h99999);
    rchk("protect", OFF_CTRL, 32'h0);
    rchk("unmapped", 32'h100, 32'h0);
    wr(OFF_SEL, 32'h0);
    $display("test init done");
  endtask
  task automatic t_switch;
    i_panel_operator.set_sw(4'h9, 2'h1);
    chk("cfg 50hz", {26'h0, 2'h2, 2'h0, 2'h0}, {26'h0, type_b, type_a, range_b, range_a});
    i_panel_operator.set_sw(4'h6, 2'h2);
    chk("cfg 1khz", {26'h0, 2'h1, 2'h1, 2'h1}, {26'h0, type_b, type_a, range_b, range_a});
    i_panel_operator.set_sw(4'h0, 2'h3);
    rchk("cfg 10khz", OFF_INPUT_CFG, 32'h3a);
    $display("test switch done");
  endtask
  task automatic t_edit;
    i_panel_operator.hold(key_s'(7'h48));
    st(2'h2, 4'h0, 3'h1);
    chk("disp", {20'h00021, 3'h1}, {disp.digits, disp.flash_pos});
    i_panel_operator.press(key_s'(7'h10));
    chk("down", 20'h09021, disp.digits);
    i_panel_operator.press(key_s'(7'h20));
    chk("up", 20'h00021, disp.digits);
    i_panel_operator.press(key_s'(7'h08));
    st(2'h2, 4'h0, 3'h2);
    repeat (3) i_panel_operator.press(key_s'(7'h08));
    st(2'h2, 4'h0, 3'h1);
    i_panel_operator.press(key_s'(7'h40));
    chk("mode 1", 20'h11000, disp.digits);
    repeat (15) i_panel_operator.press(key_s'(7'h40));
    chk("mode wrap", 20'h00021, disp.digits);
    i_panel_operator.press(key_s'(7'h02));
    st(2'h1, 4'h0, 3'h1);
    $display("test edit done");
  endtask
  task automatic t_store;
    i_panel_operator.hold(key_s'(7'h48));
    i_panel_operator.press(key_s'(7'h20));
    i_panel_operator.press(key_s'(7'h02));
    rchk("dropped", OFF_MODE_DATA, 32'h0021);
    i_panel_operator.hold(key_s'(7'h48));
    i_panel_operator.press(key_s'(7'h20));
    i_panel_operator.press(key_s'(7'h04));
    rchk("stored", OFF_MODE_DATA, 32'h1021);
    rchk("state", OFF_STATUS, 32'h1, 32'h3);
    wr(OFF_CTRL, 32'h1);
    i_panel_operator.hold(key_s'(7'h48));
    i_panel_operator.press(key_s'(7'h20));
    chk("locked", 20'h01021, disp.digits);
    i_panel_operator.press(key_s'(7'h04));
    rchk("locked store", OFF_MODE_DATA, 32'h1021);
    wr(OFF_CTRL, 32'h0);
    i_panel_operator.hold(key_s'(7'h40));
    rchk("preset state", OFF_STATUS, 32'h3, 32'h3);
    chk("lamp", 32'h8, {28'h0, disp.lamp});
    i_panel_operator.press(key_s'(7'h40));
    chk("lamp 2", 32'h4, {28'h0, disp.lamp});
    rchk("display", OFF_DISPLAY, 32'h99999);
    i_panel_operator.press(key_s'(7'h02));
    $display("test store done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog sized well past the sum of all presses
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    t_init();
    t_switch();
    t_edit();
    t_store();
    end_of_test();
  end
endmodule
